// ### dv/tar_rc_model.sv
// Purpose: upstream root complex presenting one transaction per request
// Assumes: the bench raises req_i for one cycle per transaction
// Notes:   released qualifier and attribute lines show the inverse of their last value, valid_o drops to zero
`timescale 1ns/1ps
module tar_rc_model (
  input  wire logic       clk_sys_i,  // system clock
  input  wire logic       reset_i,    // async reset
  input  wire logic       req_i,      // present one transaction
  input  wire logic       dev_i,      // target is a device, e.g. interrupt message
  input  wire logic [5:0] flags_i,    // secure, translated, no snoop, exec, elev, world
  output logic            valid_o,    // transaction present
  output logic      [5:0] flags_o,    // qualifiers on the bus
  output logic      [1:0] mt_o,       // incoming memory type
  output logic      [2:0] hint_o,     // incoming hints
  output logic      [1:0] sh_o        // incoming shareability
);
  // fixed cacheable shareable attribute, device type toward devices
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      flags_o <= 6'h00;
      mt_o    <= 2'h0;
      hint_o  <= 3'h0;
      sh_o    <= 2'h0;
    end else if (req_i) begin
      valid_o <= 1'b1;
      flags_o <= flags_i;
      mt_o    <= dev_i ? 2'h0 : 2'h3;
      hint_o  <= dev_i ? 3'h0 : 3'h6;
      sh_o    <= dev_i ? 2'h2 : 2'h3;
    end else begin
      valid_o <= 1'b0;
      flags_o <= ~flags_o;
      mt_o    <= ~mt_o;
      hint_o  <= ~hint_o;
      sh_o    <= ~sh_o;
    end
  end
endmodule

// ### dv/tar_resolver_asserts.sv
// Purpose: port-level checks of the transaction attribute resolver
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound to every resolver instance at the foot of this file
`timescale 1ns/1ps
module tar_resolver_asserts
  import tar_pkg::*;
#(
  parameter int NO_SNOOP_CAP = 1,  // snoop bypass flag honoured
  parameter int ATS_ATTR_CAP = 1   // ats attribute encoding present
) (
  input wire logic        clk_sys_i,        // system clock
  input wire logic        reset_i,          // async reset
  input wire logic        reg_rd_i,         // read strobe
  input wire logic [31:0] reg_rdata_o,      // read data
  input wire logic        txn_valid_i,      // transaction present
  input wire logic        txn_secure_i,     // secure stream
  input wire logic        txn_translated_i, // translated access
  input wire logic        txn_no_snoop_i,   // snoop bypass flag
  input wire logic [1:0]  ats_mt_i,         // page type
  input wire logic [2:0]  ats_hint_i,       // page hints
  input wire logic [1:0]  ats_sh_i,         // page shareability
  input wire logic        out_valid_o,      // result pulse
  input wire logic        out_world_o,      // resolved world
  input wire logic [1:0]  out_mt_o,         // resolved type
  input wire logic [2:0]  out_hint_o,       // resolved hints
  input wire logic [1:0]  out_sh_o,         // resolved shareability
  input wire logic [1:0]  ats_mt_o,         // completion type
  input wire logic [2:0]  ats_hint_o,       // completion hints
  input wire logic [1:0]  ats_sh_o,         // completion shareability
  input wire logic        ats_n_bit_o       // completion no-snoop bit
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // an accepted transaction and its result pulse
  sequence s_txn;
    txn_valid_i;
  endsequence
  sequence s_result;
    out_valid_o;
  endsequence

  // one result exactly one cycle after each transaction, none otherwise
  a_result_latency: assert property (s_txn |=> s_result)
    else $error("result pulse missing after transaction");
  a_no_spurious: assert property (!txn_valid_i |=> !out_valid_o)
    else $error("result pulse without transaction");
  // read data stands only in the cycle after a read strobe
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_n_bit_zero: assert property (ats_n_bit_o == 1'b0)
    else $error("completion no-snoop bit set");
  a_nonsec_world: assert property (s_txn ##0 !txn_secure_i |=> out_world_o)
    else $error("non-secure stream left as secure");
  a_device_plain: assert property (out_valid_o && out_mt_o == 2'h0 |->
    out_hint_o == 3'h0 && out_sh_o == TAR_SH_OSH)
    else $error("device type carries hints or shareability");
  a_snoop_pulldown: assert property (s_txn ##0 (txn_no_snoop_i && NO_SNOOP_CAP == 1) |=> out_mt_o < 2'h2)
    else $error("no-snoop access left cacheable");
  a_ats_presnoop: assert property (s_txn ##0 !txn_no_snoop_i |=>
    {ats_mt_o, ats_hint_o, ats_sh_o} == {out_mt_o, out_hint_o, out_sh_o})
    else $error("completion attribute differs from output");
  a_ats_page: assert property (s_txn ##0 (txn_translated_i && !txn_no_snoop_i && ats_mt_i != 2'h0
    && ATS_ATTR_CAP == 1) |=> out_mt_o == $past(ats_mt_i) && out_hint_o == $past(ats_hint_i)
    && out_sh_o == $past(ats_sh_i))
    else $error("translated access lost its page attribute");
endmodule

bind tar_resolver tar_resolver_asserts #(.NO_SNOOP_CAP(NO_SNOOP_CAP), .ATS_ATTR_CAP(ATS_ATTR_CAP)) chk_u (
  .clk_sys_i, .reset_i, .reg_rd_i, .reg_rdata_o, .txn_valid_i, .txn_secure_i, .txn_translated_i,
  .txn_no_snoop_i, .ats_mt_i, .ats_hint_i, .ats_sh_i, .out_valid_o, .out_world_o, .out_mt_o,
  .out_hint_o, .out_sh_o, .ats_mt_o, .ats_hint_o, .ats_sh_o, .ats_n_bit_o
);

// ### dv/testbench.sv
// Purpose: self-checking bench of the attribute resolver
// Assumes: default capability parameters except ATS_ATTR_CAP 0 on the second resolver, all overrides supported
// Notes:   expected attribute vectors are {exec, elev, world, type, hints, shareability}
`timescale 1ns/1ps
`include "tar_regs.svh"
module testbench;
  logic        clk_sys_i, reset_i, reg_wr_i, reg_rd_i, req, dev;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [5:0]  flags;
  logic        ste_bypass_i, ste_s1_i, ste_s2_i, s1_world_i, s1_table_world_i, s1_walk_world_i;
  logic [14:0] ste_ovr_i;
  logic [2:0]  s1_attr_sel_i, ats_hint_i, out_hint_o, ats_hint_o, txn_hint_i;
  logic [1:0]  s1_sh_i, s2_mt_i, s2_sh_i, ats_mt_i, ats_sh_i, out_mt_o, out_sh_o, ats_mt_o, ats_sh_o;
  logic [1:0]  txn_mt_i, txn_sh_i, fix_mt, fix_sh;
  logic [2:0]  fix_hint;
  logic        txn_valid_i, out_valid_o, out_exec_o, out_elev_o, out_world_o, ats_n_bit_o;
  wire logic   txn_secure_i, txn_translated_i, txn_no_snoop_i, txn_exec_i, txn_elev_i, txn_world_i;
  int          errors, check_count;

  tar_rc_model rc_u (
    .clk_sys_i, .reset_i, .req_i(req), .dev_i(dev), .flags_i(flags), .valid_o(txn_valid_i),
    .flags_o({txn_secure_i, txn_translated_i, txn_no_snoop_i, txn_exec_i, txn_elev_i, txn_world_i}),
    .mt_o(txn_mt_i), .hint_o(txn_hint_i), .sh_o(txn_sh_i)
  );
  tar_resolver dut_u (
    .clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .txn_valid_i, .txn_secure_i, .txn_translated_i, .txn_no_snoop_i, .txn_exec_i, .txn_elev_i,
    .txn_world_i, .txn_mt_i, .txn_hint_i, .txn_sh_i, .ste_bypass_i, .ste_s1_i, .ste_s2_i, .ste_ovr_i,
    .s1_attr_sel_i, .s1_sh_i, .s1_world_i, .s1_table_world_i, .s1_walk_world_i, .s2_mt_i, .s2_sh_i,
    .ats_mt_i, .ats_hint_i, .ats_sh_i, .out_valid_o, .out_exec_o, .out_elev_o, .out_world_o,
    .out_mt_o, .out_hint_o, .out_sh_o, .ats_mt_o, .ats_hint_o, .ats_sh_o, .ats_n_bit_o
  );
  // second resolver without ats attribute encoding, fixed attribute path
  tar_resolver #(.ATS_ATTR_CAP(0)) dut_fixed_u (
    .clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(),
    .txn_valid_i, .txn_secure_i, .txn_translated_i, .txn_no_snoop_i, .txn_exec_i, .txn_elev_i,
    .txn_world_i, .txn_mt_i, .txn_hint_i, .txn_sh_i, .ste_bypass_i, .ste_s1_i, .ste_s2_i, .ste_ovr_i,
    .s1_attr_sel_i, .s1_sh_i, .s1_world_i, .s1_table_world_i, .s1_walk_world_i, .s2_mt_i, .s2_sh_i,
    .ats_mt_i, .ats_hint_i, .ats_sh_i, .out_valid_o(), .out_exec_o(), .out_elev_o(), .out_world_o(),
    .out_mt_o(fix_mt), .out_hint_o(fix_hint), .out_sh_o(fix_sh), .ats_mt_o(), .ats_hint_o(), .ats_sh_o(),
    .ats_n_bit_o()
  );

  // 25 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask

  // one transaction through the root complex, result one cycle after acceptance
  task automatic txn(input logic [6:0] f, input logic [2:0] cfg, input logic [14:0] ovr,
                     input logic [11:0] pg, input logic [6:0] ats, input logic [9:0] exp);
    @(posedge clk_sys_i);
    req   <= 1'b1;
    dev   <= f[6];
    flags <= f[5:0];
    {ste_bypass_i, ste_s1_i, ste_s2_i} <= cfg;
    ste_ovr_i <= ovr;
    {s1_attr_sel_i, s1_sh_i, s1_world_i, s1_table_world_i, s1_walk_world_i, s2_mt_i, s2_sh_i} <= pg;
    {ats_mt_i, ats_hint_i, ats_sh_i} <= ats;
    @(posedge clk_sys_i);
    req <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk({31'h0, out_valid_o}, 32'h1);
    chk({22'h0, out_exec_o, out_elev_o, out_world_o, out_mt_o, out_hint_o, out_sh_o}, {22'h0, exp});
    chk({31'h0, ats_n_bit_o}, 32'h0);
  endtask

  // counts and verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    reset_i = 1'b1;
    {reg_wr_i, reg_rd_i, req, dev} = 4'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    flags = 6'h00;
    {ste_bypass_i, ste_s1_i, ste_s2_i} = 3'h0;
    ste_ovr_i = 15'h0;
    {s1_attr_sel_i, s1_sh_i, s1_world_i, s1_table_world_i, s1_walk_world_i, s2_mt_i, s2_sh_i} = 12'h0;
    {ats_mt_i, ats_hint_i, ats_sh_i} = 7'h0;
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1 chk({30'h0, out_valid_o, out_world_o}, 32'h1);
    // every register and one unmapped place read zero after reset
    for (int a = 0; a <= 24; a += 4) begin
      rd_chk(8'(a), 32'h0);
    end
    // status is read-only, unmapped writes land nowhere
    reg_wr(`TAR_STAT_OFS, 32'hffff_ffff);
    reg_wr(8'h18, 32'hffff_ffff);
    rd_chk(`TAR_STAT_OFS, 32'h0);
    rd_chk(8'h18, 32'h0);
    // disabled unit: non-secure then secure global bypass words
    reg_wr(`TAR_GBYP_OFS, 32'h5b6b);
    rd_chk(`TAR_GBYP_OFS, 32'h5b6b);
    txn(7'b0_000010, 3'b000, 15'h0, 12'h0, 7'h0, 10'b1011010110);
    reg_wr(`TAR_SGBYP_OFS, 32'h7e60);
    txn(7'b1_100101, 3'b000, 15'h0, 12'h0, 7'h0, 10'b1000000010);
    // enabled: stream bypass, stage 1, both stages, stage 2, translated
    reg_wr(`TAR_CTRL_OFS, 32'h3);
    txn(7'b0_001110, 3'b100, 15'h20c2, 12'h0, 7'h0, 10'b0110111011);
    reg_wr(`TAR_TBL_HI_OFS, 32'h0000_1b00);
    txn(7'b0_100010, 3'b010, 15'h1200, 12'b101_00_001_00_00, 7'h0, 10'b0111100100);
    txn(7'b0_101001, 3'b011, 15'h12c0, 12'b101_00_000_10_10, 7'h0, 10'b0000100010);
    chk({25'h0, ats_mt_o, ats_hint_o, ats_sh_o}, {25'h0, 7'b10_110_10});
    txn(7'b0_100111, 3'b001, 15'h17e0, 12'b000_00_000_11_11, 7'h0, 10'b1101101111);
    txn(7'b0_010100, 3'b010, 15'h0, 12'h0, 7'b01_010_10, 10'b1010101010);
    chk({25'h0, fix_mt, fix_hint, fix_sh}, {25'h0, 7'b11_110_11});
    rd_chk(`TAR_STAT_OFS, 32'h0000_06c9);
    test_done;
  end
endmodule

// ### shared/tar_pkg.sv
// Purpose: types of the transaction attribute resolver
// Assumes: none
// Notes:   memory types ordered from weakest caching to strongest
package tar_pkg;
  typedef enum logic [1:0] {TAR_MT_DEV, TAR_MT_NC, TAR_MT_WT, TAR_MT_WB} tar_mtype_e;
  typedef logic [1:0] tar_sh_t;
  localparam tar_sh_t TAR_SH_NSH = 2'h0;
  localparam tar_sh_t TAR_SH_KEEP = 2'h1;
  localparam tar_sh_t TAR_SH_OSH = 2'h2;
  localparam tar_sh_t TAR_SH_ISH = 2'h3;
  typedef enum logic [2:0] {TAR_C_S1, TAR_C_S12, TAR_C_S2, TAR_C_BYP, TAR_C_OFF} tar_case_e;
endpackage

// ### shared/tar_regs.svh
// Purpose: register offsets, field positions and reset values of the attribute resolver
// Assumes: byte addresses on an 8-bit register port, 32-bit data words
// Notes:   override word layout is shared by stream entry and both bypass words
`ifndef TAR_REGS_SVH
`define TAR_REGS_SVH

// register byte offsets
`define TAR_CTRL_OFS        8'h00
`define TAR_GBYP_OFS        8'h04
`define TAR_SGBYP_OFS       8'h08
`define TAR_TBL_LO_OFS      8'h0c
`define TAR_TBL_HI_OFS      8'h10
`define TAR_STAT_OFS        8'h14

// control word bits
`define TAR_CTRL_EN_BIT     0
`define TAR_CTRL_SEN_BIT    1

// override word fields (lsb, width)
`define TAR_OVR_W           15
`define TAR_OVR_EXEC_LSB    0
`define TAR_OVR_ELEV_LSB    2
`define TAR_OVR_WORLD_LSB   4
`define TAR_OVR_MTEN_BIT    6
`define TAR_OVR_MK_LSB      7
`define TAR_OVR_ALLOC_LSB   9
`define TAR_OVR_SH_LSB      13

// attribute table entry fields
`define TAR_ENT_W           8
`define TAR_ENT_MT_LSB      0
`define TAR_ENT_HINT_LSB    2

// status word fields
`define TAR_STAT_MT_LSB     0
`define TAR_STAT_HINT_LSB   2
`define TAR_STAT_SH_LSB     5
`define TAR_STAT_WORLD_BIT  7
`define TAR_STAT_ELEV_BIT   8
`define TAR_STAT_EXEC_BIT   9
`define TAR_STAT_SEEN_BIT   10

// reset values
`define TAR_CTRL_RST        2'h0
`define TAR_OVR_RST         15'h0000
`define TAR_TBL_RST         32'h0000_0000

`endif

// ### verilog/tar_resolver.sv
// Purpose: resolve output attributes of each transaction crossing the translation unit
// Assumes: stream entry, descriptor and stage lookups arrive on the same clock with the request
// Notes:   one register stage; hints are {read_allocate, write_allocate, short_lived_hint}
//
// Function
// - execute and elevated access come from stream overrides when enabled, global bypass overrides when not.
// - a secure stream takes its world from the effective stage 1 walk, the stream override, secure bypass, or its input when translated.
// - a non-secure stream always leaves as non-secure whatever its input, overrides or descriptors say.
// - translated memory type is the table entry picked by stage 1, combined with stage 2 when present.
// - stream bypass takes the stream type override, a disabled unit the global bypass type override.
// - stage 1 hints come from the entry for device or non-cacheable input, else combine override and entry.
// - stage 2 hints take only the allocation override, with no stage 2 combine; bypass and disabled use their own override.
// - shareability follows stage 1, stage 2 combine, stream override or global override per case.
// - any device memory type disregards hints and shareability configuration.
// - a set no-snoop flag turns a final cacheable type into non-cacheable outer-shareable.
// - translation completions carry their no-snoop bit as zero, with no per-page control.
// - the attribute handed to completion encoding is taken before the no-snoop downgrade.
// - with ATS attributes a translated access skips translation but gets the page attributes.
// - without ATS attributes a translated access gets the fixed cacheable shareable attribute.
`timescale 1ns/1ps
`include "tar_regs.svh"

module tar_resolver
  import tar_pkg::*;
#(
  parameter int PERM_OVR_CAP  = 1,     // permission_override_capable
  parameter int TYPE_OVR_CAP  = 1,     // type_override_capable
  parameter int NO_SNOOP_CAP  = 1,     // snoop bypass flag honoured
  parameter int ATS_ATTR_CAP  = 1      // ats attribute encoding present
) (
  input  wire logic         clk_sys_i,          // system clock, 25 MHz
  input  wire logic         reset_i,            // async reset, active high
  input  wire logic [7:0]   reg_addr_i,         // register byte address
  input  wire logic [31:0]  reg_wdata_i,        // register write data
  input  wire logic         reg_wr_i,           // write strobe
  input  wire logic         reg_rd_i,           // read strobe
  output logic      [31:0]  reg_rdata_o,        // read data, cycle after strobe
  input  wire logic         txn_valid_i,        // transaction present
  input  wire logic         txn_secure_i,       // secure stream
  input  wire logic         txn_translated_i,   // ats translated access
  input  wire logic         txn_no_snoop_i,     // snoop bypass flag
  input  wire logic         txn_exec_i,         // incoming execute_access
  input  wire logic         txn_elev_i,         // incoming elevated_access
  input  wire logic         txn_world_i,        // incoming world_select_bit
  input  wire logic [1:0]   txn_mt_i,           // incoming memory_type
  input  wire logic [2:0]   txn_hint_i,         // incoming hints
  input  wire logic [1:0]   txn_sh_i,           // incoming coherency_domain
  input  wire logic         ste_bypass_i,       // stream entry selects bypass
  input  wire logic         ste_s1_i,           // stage 1 translates
  input  wire logic         ste_s2_i,           // stage 2 translates
  input  wire logic [14:0]  ste_ovr_i,          // stream override word
  input  wire logic [2:0]   s1_attr_sel_i,      // page_attr_selector
  input  wire logic [1:0]   s1_sh_i,            // stage 1 coherency_domain
  input  wire logic         s1_world_i,         // final descriptor world
  input  wire logic         s1_table_world_i,   // table_world_flag on the walk
  input  wire logic         s1_walk_world_i,    // walk_world_setting
  input  wire logic [1:0]   s2_mt_i,            // stage 2 memory type
  input  wire logic [1:0]   s2_sh_i,            // stage 2 coherency_domain
  input  wire logic [1:0]   ats_mt_i,           // decoded page type of translated access
  input  wire logic [2:0]   ats_hint_i,         // decoded page hints
  input  wire logic [1:0]   ats_sh_i,           // decoded page shareability
  output logic              out_valid_o,        // resolved transaction
  output logic              out_exec_o,         // resolved execute_access
  output logic              out_elev_o,         // resolved elevated_access
  output logic              out_world_o,        // resolved world, 1 = non-secure
  output logic      [1:0]   out_mt_o,           // resolved memory_type
  output logic      [2:0]   out_hint_o,         // resolved hints
  output logic      [1:0]   out_sh_o,           // resolved coherency_domain
  output logic      [1:0]   ats_mt_o,           // attribute for completion encoding
  output logic      [2:0]   ats_hint_o,         // hints for completion encoding
  output logic      [1:0]   ats_sh_o,           // shareability for completion encoding
  output logic              ats_n_bit_o         // completion no-snoop bit
);

  // elaboration check of capability parameters
  if (PERM_OVR_CAP > 1 || TYPE_OVR_CAP > 1 || NO_SNOOP_CAP > 1 || ATS_ATTR_CAP > 1 ||
      PERM_OVR_CAP < 0 || TYPE_OVR_CAP < 0 || NO_SNOOP_CAP < 0 || ATS_ATTR_CAP < 0) begin : g_chk
    $error("capability parameters must be 0 or 1");
  end

  // two-bit force override: 1x forces bit 0, 0x keeps input
  function automatic logic ovr_bit(input logic [1:0] code, input logic in_v);
    ovr_bit = code[1] ? code[0] : in_v;
  endfunction

  // combine two types, the weaker caching wins
  function automatic logic [1:0] mt_comb(input logic [1:0] a, input logic [1:0] b);
    mt_comb = (a < b) ? a : b;
  endfunction

  // combine two shareabilities, the wider domain wins
  function automatic tar_sh_t sh_comb(input tar_sh_t a, input tar_sh_t b);
    if (a == TAR_SH_OSH || b == TAR_SH_OSH) begin
      sh_comb = TAR_SH_OSH;
    end else if (a == TAR_SH_ISH || b == TAR_SH_ISH) begin
      sh_comb = TAR_SH_ISH;
    end else begin
      sh_comb = TAR_SH_NSH;
    end
  endfunction

  // combine hints: allocate needs both, transient from either
  function automatic logic [2:0] hint_comb(input logic [2:0] a, input logic [2:0] b);
    hint_comb = {a[2] & b[2], a[1] & b[1], a[0] | b[0]};
  endfunction

  // register and output state
  logic [1:0]   ctrl_reg, ctrl_next;
  logic [14:0]  gbyp_reg, gbyp_next, sgbyp_reg, sgbyp_next;
  logic [31:0]  tbl_lo_reg, tbl_lo_next, tbl_hi_reg, tbl_hi_next, rdata_reg, rdata_next;
  logic [10:0]  stat_reg, stat_next;
  logic         valid_reg, valid_next, exec_reg, exec_next, elev_reg, elev_next, world_reg, world_next;
  logic [1:0]   mt_reg, mt_next, sh_reg, sh_next, amt_reg, amt_next, ash_reg, ash_next;
  logic [2:0]   hint_reg, hint_next, ahint_reg, ahint_next;

  // resolution intermediates
  tar_case_e    tcase;
  logic [14:0]  ovr;
  logic [63:0]  tbl;
  logic [7:0]   entry;
  logic [1:0]   e_mt, o_mt, r_mt;
  logic [2:0]   e_hint, o_hint, r_hint;
  tar_sh_t      o_sh, r_sh;
  logic         unit_en, o_exec, o_elev, o_world, r_world;

  // pick translation case and the override word in force
  always_comb begin
    unit_en = txn_secure_i ? ctrl_reg[`TAR_CTRL_SEN_BIT] : ctrl_reg[`TAR_CTRL_EN_BIT];
    ovr = unit_en ? ste_ovr_i : (txn_secure_i ? sgbyp_reg : gbyp_reg);
    if (!unit_en) begin
      tcase = TAR_C_OFF;
    end else if (ste_bypass_i) begin
      tcase = TAR_C_BYP;
    end else if (ste_s1_i && ste_s2_i) begin
      tcase = TAR_C_S12;
    end else if (ste_s1_i) begin
      tcase = TAR_C_S1;
    end else begin
      tcase = TAR_C_S2;
    end
    tbl = {tbl_hi_reg, tbl_lo_reg};
    entry = tbl[{s1_attr_sel_i, 3'h0} +: `TAR_ENT_W];
    e_mt = entry[`TAR_ENT_MT_LSB +: 2];
    e_hint = entry[`TAR_ENT_HINT_LSB +: 3];
  end

  // apply the effective overrides to the incoming attributes
  always_comb begin
    o_exec = (PERM_OVR_CAP != 0) ? ovr_bit(ovr[`TAR_OVR_EXEC_LSB +: 2], txn_exec_i) : txn_exec_i;
    o_elev = (PERM_OVR_CAP != 0) ? ovr_bit(ovr[`TAR_OVR_ELEV_LSB +: 2], txn_elev_i) : txn_elev_i;
    o_world = (PERM_OVR_CAP != 0) ? ovr_bit(ovr[`TAR_OVR_WORLD_LSB +: 2], txn_world_i) : txn_world_i;
    o_mt = txn_mt_i;
    o_hint = txn_hint_i;
    o_sh = txn_sh_i;
    if (TYPE_OVR_CAP != 0) begin
      o_mt = ovr[`TAR_OVR_MTEN_BIT] ? ovr[`TAR_OVR_MK_LSB +: 2] : txn_mt_i;
      o_hint = ovr[`TAR_OVR_ALLOC_LSB + 3] ? ovr[`TAR_OVR_ALLOC_LSB +: 3] : txn_hint_i;
      o_sh = (ovr[`TAR_OVR_SH_LSB +: 2] != TAR_SH_KEEP) ? ovr[`TAR_OVR_SH_LSB +: 2] : txn_sh_i;
    end
  end

  // resolve type, hints, shareability and world per case
  always_comb begin
    r_mt = o_mt;
    r_hint = o_hint;
    r_sh = o_sh;
    r_world = o_world;
    case (tcase)
      TAR_C_S1, TAR_C_S12: begin
        r_mt = e_mt;
        if (o_mt == TAR_MT_DEV || o_mt == TAR_MT_NC) begin
          r_hint = e_hint;
        end else begin
          r_hint = hint_comb(o_hint, e_hint);
        end
        r_sh = s1_sh_i;
        r_world = s1_world_i | s1_table_world_i | s1_walk_world_i;
        if (tcase == TAR_C_S12) begin
          r_mt = mt_comb(e_mt, s2_mt_i);
          r_sh = sh_comb(s1_sh_i, s2_sh_i);
        end
      end
      TAR_C_S2: begin
        r_mt = mt_comb(o_mt, s2_mt_i);
        r_hint = o_hint;
        r_sh = sh_comb(o_sh, s2_sh_i);
      end
      TAR_C_BYP, TAR_C_OFF: begin
        r_mt = o_mt;
        r_hint = o_hint;
        r_sh = o_sh;
      end
      default: r_mt = o_mt;
    endcase
    if (txn_translated_i) begin
      if (ATS_ATTR_CAP != 0) begin
        r_mt = ats_mt_i;
        r_hint = ats_hint_i;
        r_sh = ats_sh_i;
      end else begin
        r_mt = TAR_MT_WB;
        r_hint = 3'h6;
        r_sh = TAR_SH_ISH;
      end
      r_world = txn_world_i;
    end
    if (r_mt == TAR_MT_DEV) begin
      r_hint = 3'h0;
      r_sh = TAR_SH_OSH;
    end
    r_world = txn_secure_i ? r_world : 1'b1;
  end

  // output stage next values
  always_comb begin
    valid_next = txn_valid_i;
    exec_next = exec_reg;
    elev_next = elev_reg;
    world_next = world_reg;
    mt_next = mt_reg;
    hint_next = hint_reg;
    sh_next = sh_reg;
    amt_next = amt_reg;
    ahint_next = ahint_reg;
    ash_next = ash_reg;
    if (txn_valid_i) begin
      exec_next = o_exec;
      elev_next = o_elev;
      world_next = r_world;
      amt_next = r_mt;
      ahint_next = r_hint;
      ash_next = r_sh;
      mt_next = r_mt;
      hint_next = r_hint;
      sh_next = r_sh;
      if (NO_SNOOP_CAP != 0 && txn_no_snoop_i && (r_mt == TAR_MT_WT || r_mt == TAR_MT_WB)) begin
        mt_next = TAR_MT_NC;
        hint_next = 3'h0;
        sh_next = TAR_SH_OSH;
      end
    end
  end

  // register file next values and read mux
  always_comb begin
    ctrl_next = ctrl_reg;
    gbyp_next = gbyp_reg;
    sgbyp_next = sgbyp_reg;
    tbl_lo_next = tbl_lo_reg;
    tbl_hi_next = tbl_hi_reg;
    rdata_next = 32'h0000_0000;
    stat_next = stat_reg;
    stat_next = valid_reg ? {1'b1, exec_reg, elev_reg, world_reg, sh_reg, hint_reg, mt_reg} : stat_reg;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `TAR_CTRL_OFS:   ctrl_next = reg_wdata_i[1:0];
        `TAR_GBYP_OFS:   gbyp_next = reg_wdata_i[`TAR_OVR_W-1:0];
        `TAR_SGBYP_OFS:  sgbyp_next = reg_wdata_i[`TAR_OVR_W-1:0];
        `TAR_TBL_LO_OFS: tbl_lo_next = reg_wdata_i;
        `TAR_TBL_HI_OFS: tbl_hi_next = reg_wdata_i;
        default:         ctrl_next = ctrl_reg;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `TAR_CTRL_OFS:   rdata_next = {30'h0, ctrl_reg};
        `TAR_GBYP_OFS:   rdata_next = {17'h0, gbyp_reg};
        `TAR_SGBYP_OFS:  rdata_next = {17'h0, sgbyp_reg};
        `TAR_TBL_LO_OFS: rdata_next = tbl_lo_reg;
        `TAR_TBL_HI_OFS: rdata_next = tbl_hi_reg;
        `TAR_STAT_OFS:   rdata_next = {21'h0, stat_reg};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= `TAR_CTRL_RST;
      gbyp_reg <= `TAR_OVR_RST;
      sgbyp_reg <= `TAR_OVR_RST;
      tbl_lo_reg <= `TAR_TBL_RST;
      tbl_hi_reg <= `TAR_TBL_RST;
      rdata_reg <= 32'h0000_0000;
      stat_reg <= 11'h000;
      valid_reg <= 1'b0;
      exec_reg <= 1'b0;
      elev_reg <= 1'b0;
      world_reg <= 1'b1;
      mt_reg <= 2'h0;
      hint_reg <= 3'h0;
      sh_reg <= 2'h0;
      amt_reg <= 2'h0;
      ahint_reg <= 3'h0;
      ash_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      gbyp_reg <= gbyp_next;
      sgbyp_reg <= sgbyp_next;
      tbl_lo_reg <= tbl_lo_next;
      tbl_hi_reg <= tbl_hi_next;
      rdata_reg <= rdata_next;
      stat_reg <= stat_next;
      valid_reg <= valid_next;
      exec_reg <= exec_next;
      elev_reg <= elev_next;
      world_reg <= world_next;
      mt_reg <= mt_next;
      hint_reg <= hint_next;
      sh_reg <= sh_next;
      amt_reg <= amt_next;
      ahint_reg <= ahint_next;
      ash_reg <= ash_next;
    end
  end

  // port drive
  assign reg_rdata_o = rdata_reg;
  assign out_valid_o = valid_reg;
  assign out_exec_o = exec_reg;
  assign out_elev_o = elev_reg;
  assign out_world_o = world_reg;
  assign out_mt_o = mt_reg;
  assign out_hint_o = hint_reg;
  assign out_sh_o = sh_reg;
  assign ats_mt_o = amt_reg;
  assign ats_hint_o = ahint_reg;
  assign ats_sh_o = ash_reg;
  assign ats_n_bit_o = 1'b0;

endmodule
